//--- pcs_sequencer.v
// instruction sequencing core with wishbone register access
`timescale 1ns/1ps
`include "pcs_map.vh"
module pcs_sequencer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o_ff,
  output reg         wb_ack_o_ff,
  // decoder side
  input  wire        skipTrue,
  input  wire        retReq,
  input  wire [12:0] stackTop,
  input  wire [5:0]  irqReq,
  output reg  [15:0] instrWord_ff,
  output reg         instrValid_ff,
  output reg  [3:0]  phase_ff,
  output reg  [12:0] instrPointer_ff,
  output reg         pushStack_ff,
  output reg  [12:0] pushAddr_ff
);
  // opcode classes in top three bits of instruction word
  localparam [2:0] OP_JMP  = 3'h6;
  localparam [2:0] OP_CALL = 3'h7;
  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_HALT = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  localparam [1:0] ST_IDLE = 2'h3;

  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [1:0]  phaseCnt_ff;
  reg  [10:0] sstCnt_ff;
  reg  [12:0] pc_ff;
  reg  [12:0] nxt_pc;
  reg         dummy_ff;
  reg         nxt_dummy;
  reg  [12:0] memAddr_ff;
  reg  [7:0]  lowWrData_ff;
  reg         lowWrPend_ff;
  reg         runEn_ff;
  reg  [5:0]  irqS1_ff;
  reg  [5:0]  irqS2_ff;
  reg  [2:0]  irqSel;
  reg         irqHit;
  reg         stackFull_ff;
  reg  [4:0]  depth_ff;
  wire [15:0] memRd;
  wire        wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o_ff;
  wire        endCycle = (phaseCnt_ff == 2'd3);
  integer     i;
  reg         haltReq_ff;
  reg         takeIrq;
  reg         takeRet;
  reg         takeSkip;
  reg         takeJump;
  reg         takeCall;
  reg         discard;
  wire        cycleEdge = (state_ff == ST_RUN) && endCycle;

  function [12:0] vecAddr;
    input [2:0] idx;
    begin
      vecAddr = `PCS_VEC_BASE + {8'h00, idx, 2'b00};
    end
  endfunction

  // jump class: top two opcode bits set
  function isJump;
    input [15:0] word;
    begin
      isJump = (word[15:14] == OP_JMP[2:1]);
    end
  endfunction

  function isCall;
    input [15:0] word;
    begin
      isCall = (word[15:13] == OP_CALL);
    end
  endfunction

  // loaded program image and debug writes arrive through the bus
  pcs_prog_mem uMem (
    .clk_sys   (clk_sys),
    .wrEn      (wbReq & wb_we_i & (wb_adr_i == `PCS_ADR_IMEM_D) & wb_sel_i[0]),
    .wrAddr    (memAddr_ff),
    .wrData    (wb_dat_i[15:0]),
    .rdAddr    (pc_ff),
    .rdData_ff (memRd)
  );

  // interrupt pins are asynchronous, two stages before use
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqS1_ff <= 6'h00;
      irqS2_ff <= 6'h00;
    end else begin
      irqS1_ff <= irqReq;
      irqS2_ff <= irqS1_ff;
    end
  end

  always @* begin
    irqSel = 3'd0;
    irqHit = 1'b0;
    for (i = `PCS_NUM_IRQ - 1; i >= 0; i = i - 1) begin
      if (irqS2_ff[i]) begin
        irqSel = i[2:0];
        irqHit = 1'b1;
      end
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phaseCnt_ff <= 2'd0;
      phase_ff    <= 4'h1;
    end else begin
      phaseCnt_ff <= phaseCnt_ff + 2'd1;
      phase_ff    <= {phase_ff[2:0], phase_ff[3]};
    end
  end

  // halt / startup state machine
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (runEn_ff) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (haltReq_ff) begin
          nxt_state = ST_HALT;
        end else if (!runEn_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_HALT: begin
        if (irqHit) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (sstCnt_ff == `PCS_SST_CYCLES - 1) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // one transfer source per instruction cycle, in priority order;
  // skip and return act on the executing word, so they beat a jump seen at fetch
  always @* begin
    takeIrq  = 1'b0;
    takeRet  = 1'b0;
    takeSkip = 1'b0;
    takeJump = 1'b0;
    takeCall = 1'b0;
    if (!lowWrPend_ff && !dummy_ff) begin
      if (irqHit && !stackFull_ff) begin
        takeIrq = 1'b1;
      end else if (retReq) begin
        takeRet = 1'b1;
      end else if (skipTrue) begin
        takeSkip = 1'b1;
      end else if (isJump(memRd)) begin
        takeJump = 1'b1;
        takeCall = isCall(memRd);
      end
    end
    // fetched word replaced by a dummy
    discard = lowWrPend_ff | dummy_ff | takeIrq | takeRet | takeSkip;
  end

  // next counter value at the end of each instruction cycle
  always @* begin
    nxt_pc    = pc_ff + 13'd1;
    nxt_dummy = 1'b0;
    if (lowWrPend_ff) begin
      nxt_pc = {pc_ff[12:8], lowWrData_ff};
    end else if (dummy_ff) begin
      // hold while the target word is fetched
      nxt_pc = pc_ff;
    end else if (takeIrq) begin
      nxt_pc = vecAddr(irqSel);
    end else if (takeRet) begin
      nxt_pc = stackTop;
    end else if (takeSkip) begin
      // fetched word dropped, counter ends two past the skip
      nxt_pc = pc_ff + 13'd1;
    end else if (takeJump) begin
      // jump or call target; decoded at fetch, so one slot is added
      nxt_pc    = memRd[12:0];
      nxt_dummy = 1'b1;
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff  <= ST_IDLE;
      sstCnt_ff <= 11'd0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_WAIT) begin
        sstCnt_ff <= sstCnt_ff + 11'd1;
      end else begin
        sstCnt_ff <= 11'd0;
      end
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pc_ff           <= `PCS_RESET_VEC;
      instrPointer_ff <= `PCS_RESET_VEC;
      dummy_ff        <= 1'b0;
      instrWord_ff    <= 16'h0000;
      instrValid_ff   <= 1'b0;
    end else if (cycleEdge) begin
      // latch fetched word for execute while fetching next
      instrWord_ff    <= memRd;
      instrValid_ff   <= ~discard;
      pc_ff           <= nxt_pc;
      instrPointer_ff <= nxt_pc;
      dummy_ff        <= nxt_dummy;
    end else if (state_ff != ST_RUN) begin
      instrValid_ff <= 1'b0;
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pushStack_ff <= 1'b0;
      pushAddr_ff  <= 13'h0000;
      depth_ff     <= 5'd0;
      stackFull_ff <= 1'b0;
    end else begin
      pushStack_ff <= 1'b0;
      if (cycleEdge && (takeIrq || takeCall)) begin
        pushStack_ff <= 1'b1;
        // an interrupt drops the fetched word, so it must come back to it
        pushAddr_ff  <= takeIrq ? pc_ff : pc_ff + 13'd1;
        if (depth_ff != `PCS_STACK_DEPTH) begin
          depth_ff <= depth_ff + 5'd1;
        end
        stackFull_ff <= (depth_ff >= `PCS_STACK_DEPTH - 1);
      end else if (cycleEdge && takeRet && depth_ff != 5'd0) begin
        depth_ff     <= depth_ff - 5'd1;
        stackFull_ff <= 1'b0;
      end
    end
  end

  // wishbone slave, ack one cycle after request
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o_ff  <= 1'b0;
      wb_dat_o_ff  <= 32'h00000000;
      runEn_ff     <= 1'b0;
      haltReq_ff   <= 1'b0;
      memAddr_ff   <= 13'h0000;
      lowWrData_ff <= 8'h00;
      lowWrPend_ff <= 1'b0;
    end else begin
      wb_ack_o_ff <= wbReq;
      if (state_ff == ST_HALT) begin
        haltReq_ff <= 1'b0;
      end
      if (state_ff == ST_RUN && endCycle) begin
        lowWrPend_ff <= 1'b0;
      end
      if (wbReq && wb_we_i) begin
        case (wb_adr_i)
          `PCS_ADR_CTRL: if (wb_sel_i[0]) begin
            runEn_ff   <= wb_dat_i[`PCS_CTRL_RUN];
            haltReq_ff <= wb_dat_i[`PCS_CTRL_HALT];
          end
          `PCS_ADR_LOW: if (wb_sel_i[0]) begin
            lowWrData_ff <= wb_dat_i[7:0];
            lowWrPend_ff <= 1'b1;
          end
          `PCS_ADR_IMEM_A: if (wb_sel_i[1:0] == 2'b11) begin
            memAddr_ff <= wb_dat_i[12:0];
          end
          default: memAddr_ff <= memAddr_ff;
        endcase
      end
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i)
          `PCS_ADR_CTRL:   wb_dat_o_ff <= {31'h0, runEn_ff};
          `PCS_ADR_LOW:    wb_dat_o_ff <= {24'h0, pc_ff[7:0]};
          `PCS_ADR_PCHI:   wb_dat_o_ff <= {19'h0, pc_ff};
          `PCS_ADR_STAT:   wb_dat_o_ff <= {24'h0, stackFull_ff, depth_ff, state_ff};
          `PCS_ADR_IMEM_A: wb_dat_o_ff <= {19'h0, memAddr_ff};
          default:         wb_dat_o_ff <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

//--- pcs_map.vh
// constants for the program counter sequencer
// Summary of operation
// - four system clocks per instruction cycle
// - fetch next while executing current
// - counter changes cost a dummy cycle
// - thirteen bit counter, 8192 words
// - counter increments after each fetch
// - taken skip discards fetched, adds two
// - low byte at 06h, page jump
// - jump call return interrupt load address
// - reset clears counter to zero
// - program memory 8192 by 16 bits
// - wake from halt waits 1024 clocks
// - interrupts load fixed vectors 004h..018h
// - sixteen level return address stack
`ifndef PCS_MAP_VH
`define PCS_MAP_VH
`define PCS_PC_W        13
`define PCS_MEM_DEPTH   8192
`define PCS_WORD_W      16
`define PCS_PHASES      4
`define PCS_SST_CYCLES  1024
`define PCS_STACK_DEPTH 16
`define PCS_RESET_VEC   13'h0000
`define PCS_VEC_BASE    13'h0004
`define PCS_NUM_IRQ     6
`define PCS_ADR_CTRL    8'h00
`define PCS_ADR_LOW     8'h06
`define PCS_ADR_PCHI    8'h08
`define PCS_ADR_STAT    8'h0c
`define PCS_ADR_IMEM_A  8'h10
`define PCS_ADR_IMEM_D  8'h14
`define PCS_CTRL_RUN    0
`define PCS_CTRL_HALT   1
`define PCS_CTRL_WAKE   2
`endif

//--- pcs_prog_mem.v
// program memory, 8192 x 16, registered read
`timescale 1ns/1ps
module pcs_prog_mem (
  // clock
  input  wire        clk_sys,
  // write port
  input  wire        wrEn,
  input  wire [12:0] wrAddr,
  input  wire [15:0] wrData,
  // read port
  input  wire [12:0] rdAddr,
  output reg  [15:0] rdData_ff
);
  reg [15:0] mem [0:8191];
  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData_ff <= mem[rdAddr];
  end
endmodule

//--- pcs_decoder_model.sv
// decoder and return stack model facing the sequencer
`timescale 1ns/1ps
module pcs_decoder_model (
  // clock
  input  wire        clk_sys,
  // from sequencer
  input  wire [15:0] instrWord_ff,
  input  wire        instrValid_ff,
  input  wire        pushStack_ff,
  input  wire [12:0] pushAddr_ff,
  // to sequencer
  output wire        skipTrue,
  output wire        retReq,
  output wire [12:0] stackTop
);
  reg [12:0] stackMem [0:15];
  reg [3:0]  sp_ff = 4'h0;
  reg        ret_ff = 1'b0;
  assign skipTrue = instrValid_ff && instrWord_ff === 16'h1000;
  assign retReq   = instrValid_ff && instrWord_ff === 16'h2000;
  // stack top on return
  // outside a return the top is not valid, so show its inverse
  assign stackTop = retReq ? stackMem[sp_ff - 4'h1] : ~stackMem[sp_ff - 4'h1];
  always @(posedge clk_sys) begin
    ret_ff <= retReq;
    if (pushStack_ff) begin
      stackMem[sp_ff] <= pushAddr_ff;
      sp_ff <= sp_ff + 4'h1;
    end else if (ret_ff && !retReq) begin
      sp_ff <= sp_ff - 4'h1;
    end
  end
endmodule

//--- pcs_checker_props.sv
// port assertions for the sequencer
`timescale 1ns/1ps
module pcs_checker (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o_ff,
  input wire [3:0]  phase_ff,
  input wire [12:0] instrPointer_ff,
  input wire        pushStack_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_RST_ZERO: assert property (disable iff (1'b0)
    sys_rst ##1 sys_rst |-> instrPointer_ff == 13'h0000 && phase_ff == 4'h1)
    else $error("counter or phase not cleared in reset");
  AST_ONEHOT: assert property ($onehot(phase_ff))
    else $error("phase not one-hot");
  AST_ROTATE: assert property (!$past(sys_rst) |->
    phase_ff == {$past(phase_ff[2:0]), $past(phase_ff[3])}) else $error("phase not rotating");
  AST_PERIOD: assert property (phase_ff[0] |=> !phase_ff[0] [*3] ##1 phase_ff[0])
    else $error("instruction cycle not four clocks");
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o_ff |=> wb_ack_o_ff)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o_ff |=> !wb_ack_o_ff)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o_ff |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  AST_PUSH_SPACE: assert property (pushStack_ff |=> !pushStack_ff [*3])
    else $error("two pushes in one instruction cycle");
endmodule
bind pcs_sequencer pcs_checker u_pcs_checker (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o_ff(wb_ack_o_ff), .phase_ff(phase_ff),
  .instrPointer_ff(instrPointer_ff), .pushStack_ff(pushStack_ff));

//--- pcs_sequencer_tb.sv
// self-checking bench for the sequencer
`timescale 1ns/1ps
module pcs_sequencer_tb;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, cyc = 1'b0, we = 1'b0;
  logic        ack, skp, ret, vld, psh;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, rd, lfsr = 32'h1d85;
  logic [5:0]  irq = 6'h00;
  logic [12:0] top, ptr, pAdr, lastPc = 13'h0, lastTgt = 13'h0;
  logic [12:0] got[$], want[$], pushes[$];
  logic [15:0] word;
  logic [3:0]  ph;
  logic [12:0] memA[11] = '{0, 1, 2, 'h100, 'h101, 'h102, 'h103, 'h200, 'h201, 4, 0};
  logic [15:0] memD[11] = '{0, 0, 'hc100, 'h1000, 'hdfff, 'he200, 'hc103, 'h2000, 0, 'hc004, 0};
  int          bad_count = 0, check_count = 0, cycNum = 0, t0 = 0;
  always #5 clk_sys = ~clk_sys;
  pcs_sequencer u_pcs_sequencer (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o_ff(rdat), .wb_ack_o_ff(ack), .skipTrue(skp), .retReq(ret), .stackTop(top),
    .irqReq(irq), .instrWord_ff(word), .instrValid_ff(vld), .phase_ff(ph),
    .instrPointer_ff(ptr), .pushStack_ff(psh), .pushAddr_ff(pAdr));
  pcs_decoder_model u_pcs_decoder_model (.clk_sys(clk_sys), .instrWord_ff(word),
    .instrValid_ff(vld), .pushStack_ff(psh), .pushAddr_ff(pAdr), .skipTrue(skp),
    .retReq(ret), .stackTop(top));
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check("ack", 1, 0);
    rd = rdat;
    cyc <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic waitGot(input int k);
    int n;
    n = 0;
    while (got.size() < k && n < 3000) begin @(posedge clk_sys); n++; end
    if (n >= 3000) check("steps", k, got.size());
  endtask
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // model of the counter: records each non-sequential step except one back to the last recorded target
  always @(posedge clk_sys) begin
    cycNum++;
    if (!sys_rst) begin
      if (ptr !== lastPc && ptr !== lastPc + 13'h1 && ptr !== lastTgt) begin
        got.push_back(ptr);
        lastTgt = ptr;
      end
      if (psh === 1'b1) pushes.push_back(pAdr);
      lastPc = ptr;
    end
  end
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    wb(0, 8'h08, 0); check("counter", 0, rd);
    wb(0, 8'h06, 0); check("low byte", 0, rd);
    wb(0, 8'h20, 0); check("unmapped", 0, rd);
    $display("test reset done");
    lfsr = lfsrNext(lfsr);
    memA[10] = 13'h140 | lfsr[5:0];
    memD[10] = 16'hc000 | memA[10];
    foreach (memA[i]) begin wb(1, 8'h10, memA[i]); wb(1, 8'h14, memD[i]); end
    wb(1, 8'h00, 1);
    waitGot(3);
    check("push", 13'h103, pushes[0]);
    wb(1, 8'h06, {24'h0, memA[10][7:0]});
    waitGot(4);
    irq <= 6'h05;
    waitGot(5);
    irq <= 6'h00;
    want = '{13'h100, 13'h200, 13'h103, memA[10], 13'h004};
    foreach (want[i]) check("target", want[i], got[i]);
    $display("test flow done");
    wb(1, 8'h00, 3);
    irq <= 6'h02;
    t0 = cycNum;
    waitGot(6);
    irq <= 6'h00;
    check("wake vector", 13'h008, got[5]);
    check("wake delay", 1, (cycNum - t0 >= 1024) && (cycNum - t0 <= 1040));
    $display("test wake done");
    close_out();
  end
endmodule
